// [sbtg_pkg.sv]
/*
 Shared constants, bus line layout, timer type and state encodings
 of the bus timing guard for both ends.
 Assumes a 25 MHz local clock for every cycle count below.
*/
package sbtg_pkg;
   localparam int MCLK_MHZ = 25;
   localparam int NS_PER_US = 1000;
   localparam int US_PER_MS = 1000;
   localparam int MS_PER_S = 1000;
   localparam int DATA_W = 8;
   localparam int DB_W = 9;
   localparam int XP_W = 8;
   localparam int PEND_W = 4;
   localparam int TMR_W = 32;

   // Delay figures in their own units
   localparam int SETTLE_NS = 400;
   localparam int RELEASE_NS = 400;
   localparam int DESKEW_NS = 45;
   localparam int HOLD_NS = 45;
   localparam int ASSERT_NS = 90;
   localparam int NEGATE_NS = 90;
   localparam int DISC_US = 200;
   localparam int RST_HOLD_US = 25;
   localparam int SEL_ABORT_US = 200;
   localparam int SEL_TMO_MS = 250;
   localparam int POWERON_S = 15;
   localparam int RST_SEL_MS = 250;

   typedef logic [TMR_W-1:0] sbtg_tmr_t;

   // Minimums round up, maximums round down
   localparam sbtg_tmr_t SETTLE_CYC = sbtg_tmr_t'((SETTLE_NS * MCLK_MHZ + NS_PER_US - 1) / NS_PER_US);
   localparam sbtg_tmr_t RELEASE_CYC = sbtg_tmr_t'(RELEASE_NS * MCLK_MHZ / NS_PER_US);
   localparam sbtg_tmr_t DESKEW_CYC = sbtg_tmr_t'((DESKEW_NS * MCLK_MHZ + NS_PER_US - 1) / NS_PER_US);
   localparam sbtg_tmr_t DESKEW2_CYC = DESKEW_CYC + DESKEW_CYC;
   localparam sbtg_tmr_t HOLD_CYC = sbtg_tmr_t'((HOLD_NS * MCLK_MHZ + NS_PER_US - 1) / NS_PER_US);
   localparam sbtg_tmr_t ASSERT_CYC = sbtg_tmr_t'((ASSERT_NS * MCLK_MHZ + NS_PER_US - 1) / NS_PER_US);
   localparam sbtg_tmr_t NEGATE_CYC = sbtg_tmr_t'((NEGATE_NS * MCLK_MHZ + NS_PER_US - 1) / NS_PER_US);
   localparam sbtg_tmr_t DISC_CYC = sbtg_tmr_t'(DISC_US * MCLK_MHZ);
   localparam sbtg_tmr_t RST_HOLD_CYC = sbtg_tmr_t'(RST_HOLD_US * MCLK_MHZ);
   localparam sbtg_tmr_t SEL_ABORT_CYC = sbtg_tmr_t'(SEL_ABORT_US * MCLK_MHZ);
   localparam sbtg_tmr_t SEL_TMO_CYC = sbtg_tmr_t'(SEL_TMO_MS * US_PER_MS * MCLK_MHZ);
   localparam sbtg_tmr_t POWERON_CYC = sbtg_tmr_t'(POWERON_S * MS_PER_S * US_PER_MS * MCLK_MHZ);
   localparam sbtg_tmr_t RST_SEL_CYC = sbtg_tmr_t'(RST_SEL_MS * US_PER_MS * MCLK_MHZ);
   // Two sync stages plus the output flop
   localparam sbtg_tmr_t SYNC_MARGIN = sbtg_tmr_t'(3);
   localparam sbtg_tmr_t CNT_START = sbtg_tmr_t'(1);

   // Bus lines, true means asserted
   typedef struct packed {
      logic rst;
      logic bsy;
      logic sel;
      logic io;
      logic req;
      logic ack;
      logic [DB_W-1:0] db;
   } sbtg_bus_t;

   localparam sbtg_bus_t BUS_IDLE = '0;
   localparam sbtg_bus_t BUS_REL = '1;

   typedef enum logic [3:0] {
      TS_IDLE = 4'h0,
      TS_SELD = 4'h1,
      TS_SBSY = 4'h2,
      TS_CIO = 4'h3,
      TS_RSEL = 4'h4,
      TS_RSET = 4'h5,
      TS_RWAIT = 4'h6,
      TS_RDROP = 4'h7,
      TS_CONN = 4'h8,
      TS_SABT = 4'h9
   } sbtg_tst_t;

   typedef enum logic [3:0] {
      IS_IDLE = 4'h0,
      IS_SEL = 4'h1,
      IS_SSET = 4'h2,
      IS_SWAIT = 4'h3,
      IS_SDROP = 4'h4,
      IS_RSELD = 4'h5,
      IS_RBSY = 4'h6,
      IS_CONN = 4'h7,
      IS_SABT = 4'h8
   } sbtg_ist_t;

   typedef enum logic [1:0] {
      XS_IDLE = 2'h0,
      XS_SET = 2'h1,
      XS_ASRT = 2'h2,
      XS_NEG = 2'h3
   } sbtg_xst_t;

   function automatic sbtg_tmr_t sat_inc(sbtg_tmr_t c);
      return (c == '1) ? c : c + 1'b1;
   endfunction
endpackage

// [sbtg_if.sv]
/*
 Bus carrier joining target end and initiator end.
 Every line is open drain: a party pulls it true when its enable is low.
*/
`timescale 1ns/1ps
`default_nettype none
interface sbtg_if;
   import sbtg_pkg::*;
   sbtg_bus_t tg_o;
   sbtg_bus_t tg_oen;
   sbtg_bus_t in_o;
   sbtg_bus_t in_oen;
   sbtg_bus_t bus;

   // Wired-OR of the asserted lines
   assign bus = (tg_o & ~tg_oen) | (in_o & ~in_oen);

   modport targ(output tg_o, output tg_oen, input bus);
   modport init(output in_o, output in_oen, input bus);
endinterface
`default_nettype wire

// [sbtg_targ.sv]
/*
 Target end of the bus timing guard: selection answer, reselection,
 synchronous REQ sending, disconnection back-off, RST drive, readiness.
 Assumes the bus arrives asynchronously and is synchronised here.
*/
// Overview of operation
// - Wait bus settle before acting on changes
// - Initiator frees data within 400 ns of I/O
// - Wait deskew before next dependent edge
// - Disconnected target waits 200 us before arbitrating
// - Hold data 45 ns after REQ/ACK assertion
// - Keep REQ/ACK negated at least 90 ns
// - Target ready within 15 s of power-on
// - Target ready within 250 ms after reset
// - Hold asserted RST at least 25 us
// - Answer selection with BSY within 200 us only
// - Wait selection time-out before giving up
// - Space REQ/ACK leading edges by transfer period
// - Bus free after BSY, SEL settle-time false
// - Keep REQ/ACK asserted at least 90 ns
`timescale 1ns/1ps
`default_nettype none
module sbtg_targ #(
   parameter sbtg_pkg::sbtg_tmr_t DISC_LIM = sbtg_pkg::DISC_CYC,
   parameter sbtg_pkg::sbtg_tmr_t SEL_ABORT_LIM = sbtg_pkg::SEL_ABORT_CYC,
   parameter sbtg_pkg::sbtg_tmr_t SEL_TMO_LIM = sbtg_pkg::SEL_TMO_CYC,
   parameter sbtg_pkg::sbtg_tmr_t POWERON_LIM = sbtg_pkg::POWERON_CYC,
   parameter sbtg_pkg::sbtg_tmr_t RST_SEL_LIM = sbtg_pkg::RST_SEL_CYC,
   parameter int XFER_W = sbtg_pkg::XP_W
) (
   input wire logic i_mclk,
   input wire logic i_rstn,
   sbtg_if.targ bus_if,
   input wire logic [sbtg_pkg::DATA_W-1:0] i_own_id,
   input wire logic [sbtg_pkg::DATA_W-1:0] i_init_id,
   input wire logic i_app_ready,
   input wire logic i_resel,
   input wire logic i_disc,
   input wire logic i_bus_reset,
   input wire logic i_tx_valid,
   input wire logic [sbtg_pkg::DATA_W-1:0] i_tx_data,
   input wire logic [XFER_W-1:0] i_xfer_period,
   output logic o_ready,
   output logic o_bus_free,
   output logic o_arb_ok,
   output logic o_conn,
   output logic o_tx_ready,
   output logic o_sel_tmo,
   output logic o_rst_busy
);
   import sbtg_pkg::*;

   typedef struct packed {
      sbtg_bus_t sy1;
      sbtg_bus_t sy2;
      sbtg_tst_t st;
      sbtg_xst_t xs;
      sbtg_tmr_t bf_cnt;
      sbtg_tmr_t ph_cnt;
      sbtg_tmr_t xf_cnt;
      sbtg_tmr_t xp_cnt;
      sbtg_tmr_t disc_cnt;
      sbtg_tmr_t rst_cnt;
      sbtg_tmr_t rdy_cnt;
      logic rst_drv;
      logic after_rst;
      logic disc_done;
      sbtg_bus_t drv;
      sbtg_bus_t oen;
      logic ready;
      logic free;
      logic arb_ok;
      logic conn;
      logic tx_ready;
      logic tmo;
   } sbtg_targ_st_t;

   localparam sbtg_targ_st_t TG_RESET = '{st: TS_IDLE, xs: XS_IDLE, oen: BUS_REL, disc_done: 1'b1, default: '0};

   sbtg_targ_st_t r_q;
   sbtg_targ_st_t r_d;
   sbtg_tmr_t rdy_lim;

   always_comb begin
      r_d = r_q;
      // Bus lines pass two flops
      r_d.sy1 = bus_if.bus;
      r_d.sy2 = r_q.sy1;
      r_d.tmo = 1'b0;
      rdy_lim = r_q.after_rst ? RST_SEL_LIM : POWERON_LIM;

      // Bus free detector
      if (r_q.sy2.bsy || r_q.sy2.sel) begin
         r_d.bf_cnt = '0;
      end else begin
         r_d.bf_cnt = sat_inc(r_q.bf_cnt);
      end
      r_d.free = (r_d.bf_cnt >= SETTLE_CYC);

      // Readiness deadlines
      r_d.rdy_cnt = sat_inc(r_q.rdy_cnt);
      if (r_q.sy2.rst) begin
         r_d.after_rst = 1'b1;
         r_d.rdy_cnt = '0;
      end
      r_d.ready = !r_q.sy2.rst && (i_app_ready || (r_q.rdy_cnt >= rdy_lim - SYNC_MARGIN));

      // Disconnection back-off
      r_d.disc_cnt = sat_inc(r_q.disc_cnt);
      if (r_q.disc_cnt >= DISC_LIM) begin
         r_d.disc_done = 1'b1;
      end

      // Own RST drive
      if (r_q.rst_drv) begin
         r_d.rst_cnt = sat_inc(r_q.rst_cnt);
         if (r_q.rst_cnt >= RST_HOLD_CYC) begin
            r_d.rst_drv = 1'b0;
         end
      end else if (i_bus_reset) begin
         r_d.rst_drv = 1'b1;
         r_d.rst_cnt = CNT_START;
      end

      r_d.ph_cnt = sat_inc(r_q.ph_cnt);
      r_d.xf_cnt = sat_inc(r_q.xf_cnt);
      r_d.xp_cnt = sat_inc(r_q.xp_cnt);

      if (r_q.sy2.rst || r_q.rst_drv) begin
         // Bus reset clears every phase
         r_d.st = TS_IDLE;
         r_d.xs = XS_IDLE;
         r_d.drv = BUS_IDLE;
         r_d.conn = 1'b0;
      end else begin
         case (r_q.st)
            TS_IDLE: begin
               r_d.ph_cnt = CNT_START;
               if (r_q.sy2.sel && !r_q.sy2.bsy && !r_q.sy2.io && (|(r_q.sy2.db[DATA_W-1:0] & i_own_id))) begin
                  r_d.st = TS_SELD;
               end else if (i_resel && r_q.free && r_q.disc_done && r_q.ready) begin
                  r_d.st = TS_RSEL;
                  r_d.drv.bsy = 1'b1;
                  r_d.drv.sel = 1'b1;
                  r_d.drv.io = 1'b1;
                  r_d.drv.db = {~^(i_own_id | i_init_id), i_own_id | i_init_id};
               end
            end
            TS_SELD: begin
               if (!r_q.sy2.sel) begin
                  r_d.st = TS_IDLE;
               end else if (r_q.ph_cnt >= SEL_ABORT_LIM - SYNC_MARGIN) begin
                  r_d.st = TS_SABT;
               end else if (r_q.ready) begin
                  r_d.drv.bsy = 1'b1;
                  r_d.st = TS_SBSY;
               end
            end
            TS_SABT: begin
               if (!r_q.sy2.sel) begin
                  r_d.st = TS_IDLE;
               end
            end
            TS_SBSY: begin
               if (!r_q.sy2.sel) begin
                  r_d.drv.io = 1'b1;
                  r_d.st = TS_CIO;
                  r_d.ph_cnt = CNT_START;
               end
            end
            TS_CIO: begin
               // Initiator lets go of data meanwhile
               if (r_q.ph_cnt >= SETTLE_CYC) begin
                  r_d.st = TS_CONN;
                  r_d.conn = 1'b1;
               end
            end
            TS_RSEL: begin
               if (r_q.ph_cnt >= DESKEW2_CYC) begin
                  r_d.drv.bsy = 1'b0;
                  r_d.st = TS_RSET;
                  r_d.ph_cnt = CNT_START;
               end
            end
            TS_RSET: begin
               if (r_q.ph_cnt >= SETTLE_CYC) begin
                  r_d.st = TS_RWAIT;
                  r_d.ph_cnt = CNT_START;
               end
            end
            TS_RWAIT: begin
               if (r_q.sy2.bsy) begin
                  r_d.drv.bsy = 1'b1;
                  r_d.st = TS_RDROP;
                  r_d.ph_cnt = CNT_START;
               end else if (r_q.ph_cnt >= SEL_TMO_LIM) begin
                  r_d.drv = BUS_IDLE;
                  r_d.tmo = 1'b1;
                  r_d.st = TS_IDLE;
               end
            end
            TS_RDROP: begin
               if (r_q.ph_cnt >= DESKEW_CYC) begin
                  r_d.drv.sel = 1'b0;
                  r_d.drv.db = '0;
                  r_d.st = TS_CONN;
                  r_d.conn = 1'b1;
               end
            end
            TS_CONN: begin
               if (i_disc && r_q.xs == XS_IDLE) begin
                  r_d.drv = BUS_IDLE;
                  r_d.conn = 1'b0;
                  r_d.st = TS_IDLE;
                  r_d.disc_done = 1'b0;
                  r_d.disc_cnt = CNT_START;
               end
            end
            default: begin
               r_d.st = TS_IDLE;
            end
         endcase

         // Synchronous REQ sender
         case (r_q.xs)
            XS_IDLE: begin
               if (r_q.tx_ready && i_tx_valid) begin
                  r_d.drv.db = {~^i_tx_data, i_tx_data};
                  r_d.xs = XS_SET;
                  r_d.xf_cnt = CNT_START;
               end
            end
            XS_SET: begin
               if (r_q.xf_cnt >= DESKEW_CYC) begin
                  r_d.drv.req = 1'b1;
                  r_d.xs = XS_ASRT;
                  r_d.xf_cnt = CNT_START;
                  r_d.xp_cnt = CNT_START;
               end
            end
            XS_ASRT: begin
               if (r_q.xf_cnt >= ASSERT_CYC && r_q.xf_cnt >= HOLD_CYC) begin
                  r_d.drv.req = 1'b0;
                  r_d.xs = XS_NEG;
                  r_d.xf_cnt = CNT_START;
               end
            end
            XS_NEG: begin
               if (r_q.xf_cnt >= NEGATE_CYC && r_q.xp_cnt >= sbtg_tmr_t'(i_xfer_period)) begin
                  r_d.xs = XS_IDLE;
               end
            end
            default: begin
               r_d.xs = XS_IDLE;
            end
         endcase
      end

      r_d.tx_ready = (r_d.st == TS_CONN) && (r_d.xs == XS_IDLE);
      r_d.arb_ok = r_d.disc_done && r_d.free;
      r_d.drv.rst = r_d.rst_drv;
      r_d.drv.ack = 1'b0;
      r_d.oen = ~r_d.drv;
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         r_q <= TG_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   assign bus_if.tg_o = r_q.drv;
   assign bus_if.tg_oen = r_q.oen;
   assign o_ready = r_q.ready;
   assign o_bus_free = r_q.free;
   assign o_arb_ok = r_q.arb_ok;
   assign o_conn = r_q.conn;
   assign o_tx_ready = r_q.tx_ready;
   assign o_sel_tmo = r_q.tmo;
   assign o_rst_busy = r_q.rst_drv;
endmodule
`default_nettype wire

// [sbtg_init.sv]
/*
 Initiator end of the bus timing guard: selection, reselection answer,
 synchronous ACK replies, data release on I/O, RST drive.
 Assumes the bus arrives asynchronously and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module sbtg_init #(
   parameter sbtg_pkg::sbtg_tmr_t SEL_ABORT_LIM = sbtg_pkg::SEL_ABORT_CYC,
   parameter sbtg_pkg::sbtg_tmr_t SEL_TMO_LIM = sbtg_pkg::SEL_TMO_CYC,
   parameter int XFER_W = sbtg_pkg::XP_W
) (
   input wire logic i_mclk,
   input wire logic i_rstn,
   sbtg_if.init bus_if,
   input wire logic [sbtg_pkg::DATA_W-1:0] i_own_id,
   input wire logic [sbtg_pkg::DATA_W-1:0] i_targ_id,
   input wire logic i_select,
   input wire logic i_bus_reset,
   input wire logic [XFER_W-1:0] i_xfer_period,
   output logic o_bus_free,
   output logic o_conn,
   output logic o_sel_tmo,
   output logic o_rx_valid,
   output logic [sbtg_pkg::DATA_W-1:0] o_rx_data,
   output logic o_rst_busy
);
   import sbtg_pkg::*;

   typedef struct packed {
      sbtg_bus_t sy1;
      sbtg_bus_t sy2;
      logic pio;
      logic preq;
      sbtg_ist_t st;
      sbtg_xst_t as;
      logic [PEND_W-1:0] pend;
      sbtg_tmr_t bf_cnt;
      sbtg_tmr_t ph_cnt;
      sbtg_tmr_t af_cnt;
      sbtg_tmr_t ap_cnt;
      sbtg_tmr_t rst_cnt;
      logic rst_drv;
      sbtg_bus_t drv;
      sbtg_bus_t oen;
      logic free;
      logic conn;
      logic tmo;
      logic rx_valid;
      logic [DATA_W-1:0] rx_data;
   } sbtg_init_st_t;

   localparam sbtg_init_st_t IN_RESET = '{st: IS_IDLE, as: XS_IDLE, oen: BUS_REL, default: '0};

   sbtg_init_st_t r_q;
   sbtg_init_st_t r_d;
   logic req_rise;
   logic ack_go;

   always_comb begin
      r_d = r_q;
      r_d.sy1 = bus_if.bus;
      r_d.sy2 = r_q.sy1;
      r_d.pio = r_q.sy2.io;
      r_d.preq = r_q.sy2.req;
      r_d.tmo = 1'b0;
      r_d.rx_valid = 1'b0;
      req_rise = r_q.sy2.req && !r_q.preq;
      ack_go = 1'b0;

      // Bus free detector
      if (r_q.sy2.bsy || r_q.sy2.sel) begin
         r_d.bf_cnt = '0;
      end else begin
         r_d.bf_cnt = sat_inc(r_q.bf_cnt);
      end
      r_d.free = (r_d.bf_cnt >= SETTLE_CYC);

      // Own RST drive
      if (r_q.rst_drv) begin
         r_d.rst_cnt = sat_inc(r_q.rst_cnt);
         if (r_q.rst_cnt >= RST_HOLD_CYC) begin
            r_d.rst_drv = 1'b0;
         end
      end else if (i_bus_reset) begin
         r_d.rst_drv = 1'b1;
         r_d.rst_cnt = CNT_START;
      end

      r_d.ph_cnt = sat_inc(r_q.ph_cnt);
      r_d.af_cnt = sat_inc(r_q.af_cnt);
      r_d.ap_cnt = sat_inc(r_q.ap_cnt);

      if (r_q.sy2.rst || r_q.rst_drv) begin
         r_d.st = IS_IDLE;
         r_d.as = XS_IDLE;
         r_d.pend = '0;
         r_d.drv = BUS_IDLE;
         r_d.conn = 1'b0;
      end else begin
         case (r_q.st)
            IS_IDLE: begin
               r_d.ph_cnt = CNT_START;
               if (r_q.sy2.sel && r_q.sy2.io && !r_q.sy2.bsy && (|(r_q.sy2.db[DATA_W-1:0] & i_own_id))) begin
                  r_d.st = IS_RSELD;
               end else if (i_select && r_q.free) begin
                  r_d.st = IS_SEL;
                  r_d.drv.bsy = 1'b1;
                  r_d.drv.sel = 1'b1;
                  r_d.drv.db = {~^(i_own_id | i_targ_id), i_own_id | i_targ_id};
               end
            end
            IS_SEL: begin
               if (r_q.ph_cnt >= DESKEW2_CYC) begin
                  r_d.drv.bsy = 1'b0;
                  r_d.st = IS_SSET;
                  r_d.ph_cnt = CNT_START;
               end
            end
            IS_SSET: begin
               if (r_q.ph_cnt >= SETTLE_CYC) begin
                  r_d.st = IS_SWAIT;
                  r_d.ph_cnt = CNT_START;
               end
            end
            IS_SWAIT: begin
               if (r_q.sy2.bsy) begin
                  r_d.st = IS_SDROP;
                  r_d.ph_cnt = CNT_START;
               end else if (r_q.ph_cnt >= SEL_TMO_LIM) begin
                  r_d.drv = BUS_IDLE;
                  r_d.tmo = 1'b1;
                  r_d.st = IS_IDLE;
               end
            end
            IS_SDROP: begin
               if (r_q.ph_cnt >= DESKEW_CYC) begin
                  r_d.drv.sel = 1'b0;
                  r_d.drv.db = '0;
                  r_d.st = IS_CONN;
                  r_d.conn = 1'b1;
               end
            end
            IS_RSELD: begin
               if (!r_q.sy2.sel) begin
                  r_d.st = IS_IDLE;
               end else if (r_q.ph_cnt >= SEL_ABORT_LIM - SYNC_MARGIN) begin
                  r_d.st = IS_SABT;
               end else begin
                  r_d.drv.bsy = 1'b1;
                  r_d.st = IS_RBSY;
               end
            end
            IS_SABT: begin
               if (!r_q.sy2.sel) begin
                  r_d.st = IS_IDLE;
               end
            end
            IS_RBSY: begin
               if (!r_q.sy2.sel) begin
                  r_d.drv.bsy = 1'b0;
                  r_d.st = IS_CONN;
                  r_d.conn = 1'b1;
               end
            end
            IS_CONN: begin
               if (r_q.free) begin
                  r_d.st = IS_IDLE;
                  r_d.conn = 1'b0;
                  r_d.drv = BUS_IDLE;
                  r_d.as = XS_IDLE;
                  r_d.pend = '0;
               end
            end
            default: begin
               r_d.st = IS_IDLE;
            end
         endcase

         // Synchronous ACK replies
         if (r_q.st == IS_CONN && !r_q.free) begin
            if (req_rise) begin
               r_d.rx_data = r_q.sy2.db[DATA_W-1:0];
               r_d.rx_valid = 1'b1;
            end
            case (r_q.as)
               XS_IDLE: begin
                  if (r_q.pend != '0 && r_q.ap_cnt >= sbtg_tmr_t'(i_xfer_period)) begin
                     ack_go = 1'b1;
                     r_d.drv.ack = 1'b1;
                     r_d.as = XS_ASRT;
                     r_d.af_cnt = CNT_START;
                     r_d.ap_cnt = CNT_START;
                  end
               end
               XS_ASRT: begin
                  if (r_q.af_cnt >= ASSERT_CYC) begin
                     r_d.drv.ack = 1'b0;
                     r_d.as = XS_NEG;
                     r_d.af_cnt = CNT_START;
                  end
               end
               XS_NEG: begin
                  if (r_q.af_cnt >= NEGATE_CYC) begin
                     r_d.as = XS_IDLE;
                  end
               end
               default: begin
                  r_d.as = XS_IDLE;
               end
            endcase
            if (req_rise && !ack_go) begin
               r_d.pend = r_q.pend + 1'b1;
            end else if (!req_rise && ack_go) begin
               r_d.pend = r_q.pend - 1'b1;
            end
         end
      end

      // Let go of data once I/O turns true
      if (r_q.sy2.io && !r_q.pio) begin
         r_d.drv.db = '0;
      end
      r_d.drv.rst = r_d.rst_drv;
      r_d.drv.io = 1'b0;
      r_d.drv.req = 1'b0;
      r_d.oen = ~r_d.drv;
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         r_q <= IN_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   assign bus_if.in_o = r_q.drv;
   assign bus_if.in_oen = r_q.oen;
   assign o_bus_free = r_q.free;
   assign o_conn = r_q.conn;
   assign o_sel_tmo = r_q.tmo;
   assign o_rx_valid = r_q.rx_valid;
   assign o_rx_data = r_q.rx_data;
   assign o_rst_busy = r_q.rst_drv;
endmodule
`default_nettype wire

// [sbtg_properties.sv]
/*
 Bus timing checks between target and initiator ends.
 Assumes the joined bus levels and the 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sbtg_properties (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire sbtg_pkg::sbtg_bus_t in_oen,
   input wire sbtg_pkg::sbtg_bus_t bus
);
   import sbtg_pkg::*;
   logic [11:0] rst_len_q;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   // Length of the current RST pulse
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_len_q <= '0;
      end else begin
         rst_len_q <= bus.rst ? rst_len_q + 1'b1 : '0;
      end
   end
   sequence req_lead_s;
      $rose(bus.req);
   endsequence
   sequence ack_lead_s;
      $rose(bus.ack);
   endsequence
   chk_req_high_min: assert property (req_lead_s |-> bus.req [*3]) else $error("req short");
   chk_ack_high_min: assert property (ack_lead_s |-> bus.ack [*3]) else $error("ack short");
   chk_req_low_min: assert property ($fell(bus.req) |-> !bus.req [*3]) else $error("req gap");
   chk_ack_low_min: assert property ($fell(bus.ack) |-> !bus.ack [*3]) else $error("ack gap");
   chk_data_hold: assert property (req_lead_s |=> $stable(bus.db) [*2]) else $error("db hold");
   chk_data_deskew: assert property (req_lead_s |-> bus.db == $past(bus.db, 2)) else $error("deskew");
   chk_rst_hold: assert property ($fell(bus.rst) |-> rst_len_q >= RST_HOLD_CYC) else $error("rst");
   chk_data_release: assert property ($rose(bus.io) |-> ##[0:10] (&in_oen.db)) else $error("release");
endmodule
`default_nettype wire

// [tb_top.sv]
/*
 Testbench: target and initiator ends joined by the carrier.
 Assumes shortened delay parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sbtg_pkg::*;
   localparam sbtg_tmr_t T_DISC = 50;
   localparam sbtg_tmr_t T_ABORT = 40;
   localparam sbtg_tmr_t T_TMO = 200;
   localparam sbtg_tmr_t T_PON = 300;
   localparam sbtg_tmr_t T_RSEL = 100;
   localparam int P_SEL = 0;
   localparam int P_RESEL = 1;
   localparam int P_DISC = 2;
   localparam int P_TRST = 3;
   localparam int P_NRST = 4;
   logic i_mclk = 1'b0;
   logic i_rstn = 1'b0;
   logic [4:0] pls = 5'h00;
   logic tx_v = 1'b0, app = 1'b0;
   logic [7:0] sel_id = 8'h01, t_oid = 8'h01, t_iid = 8'h80, n_oid = 8'h80, xper = 8'h0c, tx_d = 8'h00, n_rxd;
   logic [9:0] flg;
   logic t_rdy, t_free, t_tmo, t_arb, t_conn, t_txr, t_rbusy, n_free, n_conn, n_tmo, n_rxv, n_rbusy;
   int n_mismatch = 0;
   int checks_done = 0;
   int cnt;
   int gap = 0;
   sbtg_if u_sbtg_if();
   assign flg = {t_tmo, t_free, n_tmo, n_rxv, t_conn, n_conn, t_arb, n_free, t_rdy, t_txr};
   always #20 i_mclk = ~i_mclk;
   // Cycles since the last received byte
   always @(posedge i_mclk) begin
      gap <= n_rxv ? 1 : gap + 1;
   end
   sbtg_targ #(.DISC_LIM(T_DISC), .SEL_ABORT_LIM(T_ABORT), .SEL_TMO_LIM(T_TMO), .POWERON_LIM(T_PON),
      .RST_SEL_LIM(T_RSEL))
   u_sbtg_targ(.i_mclk(i_mclk), .i_rstn(i_rstn), .bus_if(u_sbtg_if), .i_own_id(t_oid), .i_init_id(t_iid),
      .i_app_ready(app), .i_resel(pls[P_RESEL]), .i_disc(pls[P_DISC]), .i_bus_reset(pls[P_TRST]),
      .i_tx_valid(tx_v), .i_tx_data(tx_d), .i_xfer_period(xper), .o_ready(t_rdy), .o_bus_free(t_free),
      .o_arb_ok(t_arb), .o_conn(t_conn), .o_tx_ready(t_txr), .o_sel_tmo(t_tmo), .o_rst_busy(t_rbusy));
   sbtg_init #(.SEL_ABORT_LIM(T_ABORT), .SEL_TMO_LIM(T_TMO))
   u_sbtg_init(.i_mclk(i_mclk), .i_rstn(i_rstn), .bus_if(u_sbtg_if), .i_own_id(n_oid), .i_targ_id(sel_id),
      .i_select(pls[P_SEL]), .i_bus_reset(pls[P_NRST]), .i_xfer_period(xper), .o_bus_free(n_free),
      .o_conn(n_conn), .o_sel_tmo(n_tmo), .o_rx_valid(n_rxv), .o_rx_data(n_rxd), .o_rst_busy(n_rbusy));
   sbtg_properties u_sbtg_properties(.i_mclk(i_mclk), .i_rstn(i_rstn), .in_oen(u_sbtg_if.in_oen),
      .bus(u_sbtg_if.bus));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Bounded wait for one flag, cycles waited in cnt
   task automatic wait_f(input int b, input int lim);
      cnt = 0;
      @(negedge i_mclk);
      while (flg[b] !== 1'b1 && cnt < lim) begin
         @(negedge i_mclk);
         cnt++;
      end
   endtask
   task automatic pulse(input int w);
      @(posedge i_mclk);
      pls <= 5'h01 << w;
      @(posedge i_mclk);
      pls <= 5'h00;
   endtask
   task automatic send(input logic [7:0] b);
      @(posedge i_mclk);
      tx_v <= 1'b1;
      tx_d <= b;
      wait_f(0, 50);
      @(posedge i_mclk);
      tx_v <= 1'b0;
      wait_f(6, 50);
      chk("rx_data", n_rxd, b);
   endtask
   initial begin
      repeat (50000) @(posedge i_mclk);
      n_mismatch++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge i_mclk);
      i_rstn <= 1'b1;
      wait_f(2, 60);
      chk("bus_free", {n_free, t_free, t_rdy}, 3'b110);
      wait_f(1, 320);
      chk("ready_time", {t_rdy, cnt > 270}, 2'b11);
      pulse(P_SEL);
      wait_f(5, 100);
      chk("sel_conn", {n_conn, t_conn}, 2'b11);
      send(8'ha5);
      @(posedge i_mclk);
      xper <= 8'h14;
      send(8'h3c);
      chk("req_space", gap >= 20, 1'b1);
      repeat (20) @(posedge i_mclk);
      pulse(P_DISC);
      @(negedge i_mclk);
      chk("arb_blocked", t_arb, 1'b0);
      wait_f(3, 120);
      chk("backoff", {t_arb, cnt >= 48}, 2'b11);
      pulse(P_RESEL);
      wait_f(4, 100);
      chk("resel_conn", {n_conn, t_conn}, 2'b11);
      pulse(P_DISC);
      wait_f(2, 100);
      @(posedge i_mclk);
      sel_id <= 8'h02;
      pulse(P_SEL);
      wait_f(7, 300);
      chk("sel_timeout", {n_tmo, cnt >= T_TMO, n_conn}, 3'b110);
      pulse(P_TRST);
      repeat (3) @(negedge i_mclk);
      chk("rst_drive", t_rbusy, 1'b1);
      repeat (640) @(negedge i_mclk);
      chk("rst_end", {t_rbusy, t_rdy}, 2'b00);
      wait_f(1, 150);
      chk("rst_ready", {t_rdy, cnt > 70}, 2'b11);
      pulse(P_NRST);
      app <= 1'b1;
      repeat (3) @(negedge i_mclk);
      chk("init_rst", n_rbusy, 1'b1);
      repeat (800) @(negedge i_mclk);
      chk("ready_final", {n_rbusy, t_rdy}, 2'b01);
      @(posedge i_mclk);
      t_iid <= 8'h40;
      pulse(P_RESEL);
      wait_f(9, 300);
      chk("resel_timeout", {t_tmo, cnt >= T_TMO, t_conn, n_conn}, 4'b1100);
      finish_test();
   end
endmodule
`default_nettype wire
